// *** verilog/iop_port_ctrl.sv ***
/*
 * Port three pin logic with direction and data registers, the pin
 * function selection of the shared serial receive and clock pins,
 * and the two-wire bus override of port five pins six and seven.
 * Assumes an AXI4-Lite master and pin inputs asynchronous to the clock.
 */
// Chosen here: the register offsets and register access over AXI4-Lite.
// Operation
// R01: Port three direction bits select output on one, input on zero; reset zero.
// R02: Port three data resets to zero; output pins drive their data bit.
// R03: Data read returns stored value for bits whose direction is one.
// R04: Data read returns pin level for bits whose direction is zero.
// R05: Receiver enable makes shared receive pin a serial input, ignoring direction.
// R06: Receiver disabled: shared receive pin follows its direction bit.
// R07: High clock select makes shared clock pin a clock input.
// R08: High clear, low set: shared clock pin drives the serial clock.
// R09: Both selects clear, synchronous mode: shared clock pin drives the clock.
// R10: Selects and mode clear: shared clock pin follows its direction bit.
// R11: Two-wire bus settings override general settings on port five pins.
// R12: Input pin levels are synchronised before they are read back.
`timescale 1ns/100ps
module iop_port_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CORE_CLK_I,
  input  wire logic              RESET_N_I,
  input  wire logic [ADDR_W-1:0] S_AWADDR_I,
  input  wire logic              S_AWVALID_I,
  output logic                   S_AWREADY_O,
  input  wire logic [31:0]       S_WDATA_I,
  input  wire logic [3:0]        S_WSTRB_I,
  input  wire logic              S_WVALID_I,
  output logic                   S_WREADY_O,
  output logic [1:0]             S_BRESP_O,
  output logic                   S_BVALID_O,
  input  wire logic              S_BREADY_I,
  input  wire logic [ADDR_W-1:0] S_ARADDR_I,
  input  wire logic              S_ARVALID_I,
  output logic                   S_ARREADY_O,
  output logic [31:0]            S_RDATA_O,
  output logic [1:0]             S_RRESP_O,
  output logic                   S_RVALID_O,
  input  wire logic              S_RREADY_I,
  input  wire logic [7:0]        P3_IN_I,
  output logic [7:0]             P3_OUT_O,
  output logic [7:0]             P3_OE_O,
  input  wire logic              RXPIN_IN_I,
  output logic                   RXPIN_OUT_O,
  output logic                   RXPIN_OE_O,
  input  wire logic              CLKPIN_IN_I,
  output logic                   CLKPIN_OUT_O,
  output logic                   CLKPIN_OE_O,
  input  wire logic [1:0]        P5_IN_I,
  output logic [1:0]             P5_OUT_O,
  output logic [1:0]             P5_OE_O,
  input  wire logic              SER_CLK_OUT_I,
  output logic                   SER_RXD_O,
  output logic                   SER_CLK_IN_O,
  input  wire logic              TWI_EN_I,
  input  wire logic              TWI_SCL_LOW_I,
  input  wire logic              TWI_SDA_LOW_I,
  output logic                   TWI_SCL_IN_O,
  output logic                   TWI_SDA_IN_O
);

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [7:0]        dir_q;
  logic [7:0]        data_q;
  logic [3:0]        ser_q;
  logic [1:0]        p2_dir_q;
  logic [1:0]        p2_data_q;
  logic [1:0]        p5_dir_q;
  logic [1:0]        p5_data_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic              wstrb0_q;
  logic              wr_fire;
  logic              wr_byte;
  logic [11:0]       pins_raw;
  logic [11:0]       pins_s;
  logic [7:0]        p3_s;
  logic [1:0]        p2_s;
  logic [1:0]        p5_s;
  logic [7:0]        p2_rb;
  logic [7:0]        p5_rb;
  logic              rx_oe_d;
  logic              rx_out_d;
  logic              clk_oe_d;
  logic              clk_out_d;
  logic [1:0]        p5_oe_d;
  logic [1:0]        p5_out_d;
  iop_pkg::iop_clkf_t clkf;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Output bits read back the stored value, input bits the pin.
  function automatic logic [7:0] readback(input logic [7:0] dir,
                                          input logic [7:0] dat,
                                          input logic [7:0] pin);
    readback = (dir & dat) | (~dir & pin);
  endfunction : readback

  function automatic logic mapped(input logic [7:0] a);
    if (a == iop_pkg::OFS_P3_DIR) begin
      mapped = 1'b1;
    end else if (a == iop_pkg::OFS_P3_DATA) begin
      mapped = 1'b1;
    end else if (a == iop_pkg::OFS_SER_CTRL) begin
      mapped = 1'b1;
    end else if (a == iop_pkg::OFS_P2_CTRL) begin
      mapped = 1'b1;
    end else if (a == iop_pkg::OFS_P5_CTRL) begin
      mapped = 1'b1;
    end else if (a == iop_pkg::OFS_STATUS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  endfunction : mapped

  // ****************************************************************
  // Pin input synchronisers.
  // ****************************************************************
  assign pins_raw = {P5_IN_I, RXPIN_IN_I, CLKPIN_IN_I, P3_IN_I};

  // R12 two-flop capture
  iop_sync #(
    .W (12)
  ) u_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     (pins_raw),
    .q_o     (pins_s)
  );

  assign p3_s = pins_s[7:0];
  assign p2_s = pins_s[9:8];
  assign p5_s = pins_s[11:10];

  assign p2_rb = readback({6'h00, p2_dir_q}, {6'h00, p2_data_q}, {6'h00, p2_s});
  assign p5_rb = readback({6'h00, p5_dir_q}, {6'h00, p5_data_q}, {6'h00, p5_s});

  // ****************************************************************
  // Write channel.
  // ****************************************************************
  assign wr_fire = !S_AWREADY_O && !S_WREADY_O && !S_BVALID_O;
  assign wr_byte = wr_fire && wstrb0_q;

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      S_AWREADY_O <= 1'b1;
      awaddr_q    <= '0;
    end else if (S_AWVALID_I && S_AWREADY_O) begin
      S_AWREADY_O <= 1'b0;
      awaddr_q    <= S_AWADDR_I;
    end else if (S_BVALID_O && S_BREADY_I) begin
      S_AWREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      S_WREADY_O <= 1'b1;
      wdata_q    <= '0;
      wstrb0_q   <= 1'b0;
    end else if (S_WVALID_I && S_WREADY_O) begin
      S_WREADY_O <= 1'b0;
      wdata_q    <= S_WDATA_I;
      wstrb0_q   <= S_WSTRB_I[0];
    end else if (S_BVALID_O && S_BREADY_I) begin
      S_WREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      S_BVALID_O <= 1'b0;
      S_BRESP_O  <= iop_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_BVALID_O <= 1'b1;
      S_BRESP_O  <= mapped(8'(awaddr_q)) ? iop_pkg::RESP_OKAY : iop_pkg::RESP_SLVERR;
    end else if (S_BREADY_I) begin
      S_BVALID_O <= 1'b0;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  // R01 direction store
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      dir_q <= iop_pkg::P3_DIR_RST;
    end else if (wr_byte && 8'(awaddr_q) == iop_pkg::OFS_P3_DIR) begin
      dir_q <= wdata_q[7:0];
    end
  end

  // R02 data store
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      data_q <= iop_pkg::P3_DATA_RST;
    end else if (wr_byte && 8'(awaddr_q) == iop_pkg::OFS_P3_DATA) begin
      data_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ser_q <= iop_pkg::SER_CTRL_RST;
    end else if (wr_byte && 8'(awaddr_q) == iop_pkg::OFS_SER_CTRL) begin
      ser_q <= wdata_q[3:0];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      p2_dir_q  <= iop_pkg::PX_DIR_RST;
      p2_data_q <= iop_pkg::PX_DATA_RST;
    end else if (wr_byte && 8'(awaddr_q) == iop_pkg::OFS_P2_CTRL) begin
      p2_dir_q  <= wdata_q[iop_pkg::PX_DIR_LSB +: 2];
      p2_data_q <= wdata_q[iop_pkg::PX_DATA_LSB +: 2];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      p5_dir_q  <= iop_pkg::PX_DIR_RST;
      p5_data_q <= iop_pkg::PX_DATA_RST;
    end else if (wr_byte && 8'(awaddr_q) == iop_pkg::OFS_P5_CTRL) begin
      p5_dir_q  <= wdata_q[iop_pkg::PX_DIR_LSB +: 2];
      p5_data_q <= wdata_q[iop_pkg::PX_DATA_LSB +: 2];
    end
  end

  // ****************************************************************
  // Read channel.
  // ****************************************************************
  // Direction bits are write-only and read as zero.
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      S_ARREADY_O <= 1'b1;
      S_RVALID_O  <= 1'b0;
      S_RDATA_O   <= '0;
      S_RRESP_O   <= iop_pkg::RESP_OKAY;
    end else if (S_ARVALID_I && S_ARREADY_O) begin
      S_ARREADY_O <= 1'b0;
      S_RVALID_O  <= 1'b1;
      S_RDATA_O   <= '0;
      S_RRESP_O   <= iop_pkg::RESP_OKAY;
      if (8'(S_ARADDR_I) == iop_pkg::OFS_P3_DATA) begin
        // R03 R04 direction-dependent readback
        S_RDATA_O[7:0] <= readback(dir_q, data_q, p3_s);
      end else if (8'(S_ARADDR_I) == iop_pkg::OFS_SER_CTRL) begin
        S_RDATA_O[3:0] <= ser_q;
      end else if (8'(S_ARADDR_I) == iop_pkg::OFS_P2_CTRL) begin
        S_RDATA_O[iop_pkg::PX_DATA_LSB +: 2] <= p2_rb[1:0];
      end else if (8'(S_ARADDR_I) == iop_pkg::OFS_P5_CTRL) begin
        S_RDATA_O[iop_pkg::PX_DATA_LSB +: 2] <= p5_rb[1:0];
      end else if (8'(S_ARADDR_I) == iop_pkg::OFS_STATUS) begin
        S_RDATA_O[iop_pkg::ST_RX_BIT]      <= ser_q[iop_pkg::SER_RXEN_BIT];
        S_RDATA_O[iop_pkg::ST_CLKF_LSB +: 2] <= clkf;
      end else if (!mapped(8'(S_ARADDR_I))) begin
        S_RRESP_O <= iop_pkg::RESP_SLVERR;
      end
    end else if (S_RVALID_O && S_RREADY_I) begin
      S_ARREADY_O <= 1'b1;
      S_RVALID_O  <= 1'b0;
    end
  end

  // ****************************************************************
  // Pin function selection.
  // ****************************************************************
  always_comb begin
    // R07 R08 R09 R10 clock pin priority
    if (ser_q[iop_pkg::SER_CKH_BIT]) begin
      clkf = iop_pkg::CLKF_IN;
    end else if (ser_q[iop_pkg::SER_CKL_BIT]) begin
      clkf = iop_pkg::CLKF_OUT;
    end else if (ser_q[iop_pkg::SER_COM_BIT]) begin
      clkf = iop_pkg::CLKF_OUT;
    end else begin
      clkf = iop_pkg::CLKF_GPIO;
    end
  end

  always_comb begin
    case (clkf)
      iop_pkg::CLKF_IN: begin
        clk_oe_d  = 1'b0;
        clk_out_d = 1'b0;
      end
      iop_pkg::CLKF_OUT: begin
        clk_oe_d  = 1'b1;
        clk_out_d = SER_CLK_OUT_I;
      end
      default: begin
        clk_oe_d  = p2_dir_q[0];
        clk_out_d = p2_data_q[0];
      end
    endcase
  end

  always_comb begin
    // R05 R06 receive pin selection
    if (ser_q[iop_pkg::SER_RXEN_BIT]) begin
      rx_oe_d  = 1'b0;
      rx_out_d = 1'b0;
    end else begin
      rx_oe_d  = p2_dir_q[1];
      rx_out_d = p2_data_q[1];
    end
  end

  always_comb begin
    // R11 two-wire bus override, open drain
    if (TWI_EN_I) begin
      p5_oe_d  = {TWI_SDA_LOW_I, TWI_SCL_LOW_I};
      p5_out_d = 2'h0;
    end else begin
      p5_oe_d  = p5_dir_q;
      p5_out_d = p5_data_q;
    end
  end

  // ****************************************************************
  // Registered pin drive.
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      P3_OUT_O     <= '0;
      P3_OE_O      <= '0;
      RXPIN_OUT_O  <= 1'b0;
      RXPIN_OE_O   <= 1'b0;
      CLKPIN_OUT_O <= 1'b0;
      CLKPIN_OE_O  <= 1'b0;
      P5_OUT_O     <= '0;
      P5_OE_O      <= '0;
    end else begin
      // R01 R02 port drive
      P3_OUT_O     <= data_q;
      P3_OE_O      <= dir_q;
      RXPIN_OUT_O  <= rx_out_d;
      RXPIN_OE_O   <= rx_oe_d;
      CLKPIN_OUT_O <= clk_out_d;
      CLKPIN_OE_O  <= clk_oe_d;
      P5_OUT_O     <= p5_out_d;
      P5_OE_O      <= p5_oe_d;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SER_RXD_O    <= 1'b1;
      SER_CLK_IN_O <= 1'b0;
      TWI_SCL_IN_O <= 1'b1;
      TWI_SDA_IN_O <= 1'b1;
    end else begin
      SER_RXD_O    <= ser_q[iop_pkg::SER_RXEN_BIT] ? p2_s[1] : 1'b1;
      SER_CLK_IN_O <= (clkf == iop_pkg::CLKF_IN) ? p2_s[0] : 1'b0;
      TWI_SCL_IN_O <= p5_s[0];
      TWI_SDA_IN_O <= p5_s[1];
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  property p_r01;
    ##1 P3_OE_O == $past(dir_q);
  endproperty
  a_r01: assert property (p_r01) else $error("port drive enable differs from direction"); // R01

  property p_r02;
    ##1 (P3_OUT_O & P3_OE_O) == ($past(data_q) & $past(dir_q));
  endproperty
  a_r02: assert property (p_r02) else $error("output pin value differs from data"); // R02

  property p_r03;
    (S_ARVALID_I && S_ARREADY_O && 8'(S_ARADDR_I) == iop_pkg::OFS_P3_DATA)
      |=> (S_RDATA_O[7:0] & $past(dir_q)) == ($past(data_q) & $past(dir_q));
  endproperty
  a_r03: assert property (p_r03) else $error("output bit read not from data"); // R03

  property p_r04;
    (S_ARVALID_I && S_ARREADY_O && 8'(S_ARADDR_I) == iop_pkg::OFS_P3_DATA)
      |=> (S_RDATA_O[7:0] & ~$past(dir_q)) == ($past(P3_IN_I, 3) & ~$past(dir_q));
  endproperty
  a_r04: assert property (p_r04) else $error("input bit read not from pin"); // R04

  property p_r05;
    ser_q[iop_pkg::SER_RXEN_BIT] |=> !RXPIN_OE_O;
  endproperty
  a_r05: assert property (p_r05) else $error("receive pin driven while receiver on"); // R05

  property p_r06;
    !ser_q[iop_pkg::SER_RXEN_BIT] |=> RXPIN_OE_O == $past(p2_dir_q[1]);
  endproperty
  a_r06: assert property (p_r06) else $error("receive pin ignores its direction"); // R06

  property p_r07;
    ser_q[iop_pkg::SER_CKH_BIT] |=> !CLKPIN_OE_O;
  endproperty
  a_r07: assert property (p_r07) else $error("clock pin driven in clock input mode"); // R07

  property p_r08;
    (ser_q[2:1] == 2'h1) |=> CLKPIN_OE_O && CLKPIN_OUT_O == $past(SER_CLK_OUT_I);
  endproperty
  a_r08: assert property (p_r08) else $error("clock pin not driving serial clock"); // R08

  property p_r09;
    (ser_q[3:1] == 3'h4) |=> CLKPIN_OE_O;
  endproperty
  a_r09: assert property (p_r09) else $error("clock pin not output in synchronous mode"); // R09

  property p_r10;
    (ser_q[3:1] == 3'h0) |=> CLKPIN_OE_O == $past(p2_dir_q[0]);
  endproperty
  a_r10: assert property (p_r10) else $error("clock pin ignores its direction"); // R10

  property p_r11;
    TWI_EN_I |=> P5_OUT_O == 2'h0 && P5_OE_O == {$past(TWI_SDA_LOW_I), $past(TWI_SCL_LOW_I)};
  endproperty
  a_r11: assert property (p_r11) else $error("two-wire bus does not own port five pins"); // R11

  property p_r12;
    ##2 p3_s == $past(P3_IN_I, 2);
  endproperty
  a_r12: assert property (p_r12) else $error("pin level not two cycles delayed"); // R12

endmodule : iop_port_ctrl

// *** verilog/iop_pkg.sv ***
/*
 * Shared constants for the port pin control block: register offsets,
 * field positions, reset values, bus response codes and pin functions.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package iop_pkg;

  // ****************************************************************
  // Register offsets (byte addresses).
  // ****************************************************************
  localparam logic [7:0] OFS_P3_DIR   = 8'h00;
  localparam logic [7:0] OFS_P3_DATA  = 8'h04;
  localparam logic [7:0] OFS_SER_CTRL = 8'h08;
  localparam logic [7:0] OFS_P2_CTRL  = 8'h0c;
  localparam logic [7:0] OFS_P5_CTRL  = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int SER_RXEN_BIT = 0;
  localparam int SER_CKL_BIT  = 1;
  localparam int SER_CKH_BIT  = 2;
  localparam int SER_COM_BIT  = 3;
  localparam int PX_DIR_LSB   = 0;
  localparam int PX_DATA_LSB  = 4;
  localparam int ST_RX_BIT    = 0;
  localparam int ST_CLKF_LSB  = 1;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] P3_DIR_RST   = 8'h00;
  localparam logic [7:0] P3_DATA_RST  = 8'h00;
  localparam logic [3:0] SER_CTRL_RST = 4'h0;
  localparam logic [1:0] PX_DIR_RST   = 2'h0;
  localparam logic [1:0] PX_DATA_RST  = 2'h0;

  // ****************************************************************
  // Bus responses and synchroniser depth.
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         SYNC_STAGES = 2;

  // ****************************************************************
  // Function of the shared serial clock pin.
  // ****************************************************************
  typedef enum logic [1:0] {
    CLKF_GPIO,
    CLKF_OUT,
    CLKF_IN
  } iop_clkf_t;

endpackage : iop_pkg

// *** verilog/iop_sync.sv ***
/*
 * Two-flop level synchroniser for a bus of pin inputs.
 * Assumes the inputs may change at any time relative to the clock.
 */
`timescale 1ns/100ps
module iop_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // ****************************************************************
  // The first stage feeds only the second stage.
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : iop_sync

// *** tb/iop_board_model.sv ***
/*
 * Board side of the port pins: resolves each pin level.
 * Assumes the bench gives the level every external driver or pull applies.
 */
`timescale 1ns/100ps
module iop_board_model (
  input  wire logic [11:0] out_i,
  input  wire logic [11:0] oe_i,
  input  wire logic [11:0] ext_i,
  output logic      [11:0] lvl_o
);
  // A pin driven by the block shows its value, otherwise the board level.
  assign lvl_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : iop_board_model

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the port pin control block.
 * Assumes the board model on the pins and drives AXI4-Lite from this file.
 */
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst_n, awv, wv, brdy, arv, rrdy, awr, wr, bv, arr, rv;
  logic [7:0]  awa, ara, p3o, p3e, p3x;
  logic [31:0] wd, rd;
  logic [1:0]  br, rr, p5o, p5e, p5x;
  logic        rxo, rxe, cko, cke, rxx, ckx, sck, srxd, sckin;
  logic        twi, scl_lo, sda_lo, scl_in, sda_in;
  logic [11:0] lvl;
  int          fails, checks;

  iop_board_model board (.out_i({p5o, cko, rxo, p3o}), .ext_i({p5x, ckx, rxx, p3x}),
                         .oe_i({p5e, cke, rxe, p3e}), .lvl_o(lvl));
  iop_port_ctrl dut (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .S_AWADDR_I(awa), .S_AWVALID_I(awv), .S_AWREADY_O(awr),
    .S_WDATA_I(wd), .S_WSTRB_I(4'hf), .S_WVALID_I(wv), .S_WREADY_O(wr),
    .S_BRESP_O(br), .S_BVALID_O(bv), .S_BREADY_I(brdy),
    .S_ARADDR_I(ara), .S_ARVALID_I(arv), .S_ARREADY_O(arr),
    .S_RDATA_O(rd), .S_RRESP_O(rr), .S_RVALID_O(rv), .S_RREADY_I(rrdy),
    .P3_IN_I(lvl[7:0]), .P3_OUT_O(p3o), .P3_OE_O(p3e),
    .RXPIN_IN_I(lvl[8]), .RXPIN_OUT_O(rxo), .RXPIN_OE_O(rxe),
    .CLKPIN_IN_I(lvl[9]), .CLKPIN_OUT_O(cko), .CLKPIN_OE_O(cke),
    .P5_IN_I(lvl[11:10]), .P5_OUT_O(p5o), .P5_OE_O(p5e),
    .SER_CLK_OUT_I(sck), .SER_RXD_O(srxd), .SER_CLK_IN_O(sckin),
    .TWI_EN_I(twi), .TWI_SCL_LOW_I(scl_lo), .TWI_SDA_LOW_I(sda_lo),
    .TWI_SCL_IN_O(scl_in), .TWI_SDA_IN_O(sda_in));

  // ****************************************************************
  // Clock, bus tasks and checks.
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic settle();
    repeat (5) @(posedge clk);
  endtask : settle

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 100);
    brdy <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, bv});
    chk("bresp", {30'h0, er}, {30'h0, br});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                        input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 100);
    rrdy <= 1'b0;
    chk("rdata", e, rd & m);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask : axi_rd

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  // port three direction and read-back.
  task automatic t_port3();
    chk("p3_oe", 32'h0, {24'h0, p3e});
    p3x <= 8'h5a;
    settle();
    axi_rd(iop_pkg::OFS_P3_DATA, 32'h5a, iop_pkg::RESP_OKAY, 32'hff);
    axi_wr(iop_pkg::OFS_P3_DIR, 32'hff, iop_pkg::RESP_OKAY);
    axi_rd(iop_pkg::OFS_P3_DATA, 32'h0, iop_pkg::RESP_OKAY, 32'hff);
    axi_wr(iop_pkg::OFS_P3_DATA, 32'ha5, iop_pkg::RESP_OKAY);
    axi_wr(iop_pkg::OFS_P3_DIR, 32'hf0, iop_pkg::RESP_OKAY);
    p3x <= 8'h3c;
    settle();
    chk("p3_oe", 32'hf0, {24'h0, p3e});
    chk("p3_drive", 32'ha0, {24'h0, p3o & p3e});
    axi_rd(iop_pkg::OFS_P3_DATA, 32'hac, iop_pkg::RESP_OKAY, 32'hff);
    axi_rd(iop_pkg::OFS_P3_DIR, 32'h0, iop_pkg::RESP_OKAY, 32'hff);
    $display("test port3 done");
  endtask : t_port3

  task automatic t_rx();
    rxx <= 1'b0;
    axi_wr(iop_pkg::OFS_P2_CTRL, 32'h22, iop_pkg::RESP_OKAY);
    axi_wr(iop_pkg::OFS_SER_CTRL, 32'h1, iop_pkg::RESP_OKAY);
    settle();
    chk("rx_oe", 32'h0, {31'h0, rxe});
    chk("ser_rxd", 32'h0, {31'h0, srxd});
    axi_rd(iop_pkg::OFS_STATUS, 32'h1, iop_pkg::RESP_OKAY, 32'h1);
    axi_wr(iop_pkg::OFS_SER_CTRL, 32'h0, iop_pkg::RESP_OKAY);
    settle();
    chk("rx_oe", 32'h1, {31'h0, rxe});
    chk("rx_out", 32'h1, {31'h0, rxo});
    axi_rd(iop_pkg::OFS_P2_CTRL, 32'h20, iop_pkg::RESP_OKAY, 32'h30);
    axi_wr(iop_pkg::OFS_P2_CTRL, 32'h20, iop_pkg::RESP_OKAY);
    settle();
    chk("rx_oe", 32'h0, {31'h0, rxe});
    $display("test rx done");
  endtask : t_rx

  task automatic t_clk();
    logic [3:0] cfg [7];
    logic [1:0] fn;
    cfg = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hf};
    ckx <= 1'b1;
    sck <= 1'b1;
    foreach (cfg[i]) begin
      fn = cfg[i][3] ? iop_pkg::CLKF_IN : (cfg[i][2] | cfg[i][1]) ? iop_pkg::CLKF_OUT : iop_pkg::CLKF_GPIO;
      axi_wr(iop_pkg::OFS_P2_CTRL, {31'h0, cfg[i][0]}, iop_pkg::RESP_OKAY);
      axi_wr(iop_pkg::OFS_SER_CTRL, {28'h0, cfg[i][1], cfg[i][3], cfg[i][2], 1'b0}, iop_pkg::RESP_OKAY);
      settle();
      chk("clk_oe", {31'h0, fn == iop_pkg::CLKF_OUT || (fn == iop_pkg::CLKF_GPIO && cfg[i][0])},
          {31'h0, cke});
      chk("clk_out", {31'h0, fn == iop_pkg::CLKF_OUT}, {31'h0, cko & cke});
      chk("clk_in", {31'h0, fn == iop_pkg::CLKF_IN}, {31'h0, sckin});
      axi_rd(iop_pkg::OFS_STATUS, {29'h0, fn, 1'b0}, iop_pkg::RESP_OKAY, 32'h6);
    end
    $display("test clk done");
  endtask : t_clk

  // two-wire bus override and unmapped access.
  task automatic t_twi();
    axi_wr(iop_pkg::OFS_P5_CTRL, 32'h33, iop_pkg::RESP_OKAY);
    twi <= 1'b1;
    scl_lo <= 1'b1;
    settle();
    chk("p5_oe", 32'h1, {30'h0, p5e});
    chk("p5_drive", 32'h0, {30'h0, p5o & p5e});
    chk("scl_in", 32'h0, {31'h0, scl_in});
    chk("sda_in", 32'h1, {31'h0, sda_in});
    twi <= 1'b0;
    scl_lo <= 1'b0;
    settle();
    chk("p5_drive", 32'h3, {30'h0, p5o & p5e});
    axi_rd(iop_pkg::OFS_P5_CTRL, 32'h30, iop_pkg::RESP_OKAY, 32'h30);
    axi_wr(8'h20, 32'hff, iop_pkg::RESP_SLVERR);
    axi_rd(8'h20, 32'h0, iop_pkg::RESP_SLVERR, 32'hffffffff);
    $display("test twi done");
  endtask : t_twi

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  initial begin
    {rst_n, awv, wv, brdy, arv, rrdy, awa, ara, wd, p3x, sck, twi, scl_lo, sda_lo, ckx} = '0;
    rxx = 1'b1;
    p5x = 2'b11;
    fails = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_port3();
    t_rx();
    t_clk();
    t_twi();
    complete_run();
  end

  initial begin
    #200000;
    fails++;
    complete_run();
  end
endmodule : tb_top
